// ===== include/iohn_err_map.svh
// Register offsets, field positions, reset values and codes
`ifndef IOHN_ERR_MAP_SVH
`define IOHN_ERR_MAP_SVH
`define IOHN_OFF_CFG     12'h000
`define IOHN_OFF_STATUS  12'h008
`define IOHN_OFF_ADDR    12'h010
`define IOHN_OFF_MISC_LO 12'h018
`define IOHN_OFF_MISC_HI 12'h01c
`define IOHN_OFF_CLEAR   12'h020
`define IOHN_CFG_COH_EN   0
`define IOHN_CFG_EXCL_DIS 1
`define IOHN_CFG_DS_PSN   2
`define IOHN_CFG_DFLT     3
`define IOHN_CFG_PERIPH   4
`define IOHN_CFG_RESET    5'h01
`define IOHN_ST_V  0
`define IOHN_ST_MV 1
`define IOHN_ST_UNC 2
`define IOHN_ST_DFR 3
`define IOHN_SRC_REQ   4'h0
`define IOHN_SRC_WDAT  4'h1
`define IOHN_SRC_BRESP 4'h2
`define IOHN_RE_OK    2'h0
`define IOHN_RE_EXOK  2'h1
`define IOHN_RE_DERR  2'h2
`define IOHN_RE_NDERR 2'h3
`define IOHN_AX_SLVERR 2'h2
`define IOHN_AX_DECERR 2'h3
`endif

// ===== include/iohn_pkg.sv
// Types for the io home node error handler
package iohn_pkg;
  typedef enum logic [1:0] {
    IOHN_EV_REQ   = 2'h0,
    IOHN_EV_WDAT  = 2'h1,
    IOHN_EV_BRESP = 2'h2,
    IOHN_EV_RRESP = 2'h3
  } iohn_kind_e;
  typedef enum logic [2:0] {
    IOHN_RQ_NONCOH = 3'h0,
    IOHN_RQ_COH_RD = 3'h1,
    IOHN_RQ_CLN_MK = 3'h2,
    IOHN_RQ_COH_WR = 3'h3,
    IOHN_RQ_ATOMIC = 3'h4,
    IOHN_RQ_STASH  = 3'h5,
    IOHN_RQ_CFG    = 3'h6,
    IOHN_RQ_OTHER  = 3'h7
  } iohn_class_e;
endpackage

// ===== verilog/iohn_err.sv
// Error classification, logging and response for the io home node
`timescale 1ns/1ps
`include "iohn_err_map.svh"

module iohn_err (
  input  wire logic                 CLK,         // Clock, 250 MHz
  input  wire logic                 RST,         // Async reset, high
  input  wire logic                 PSEL,        // APB select
  input  wire logic                 PENABLE,     // APB access phase
  input  wire logic                 PWRITE,      // APB direction
  input  wire logic [11:0]          PADDR,       // APB byte address
  input  wire logic [31:0]          PWDATA,      // APB write data
  output logic      [31:0]          PRDATA,      // APB read data
  output logic                      PREADY,      // APB ready
  output logic                      PSLVERR,     // APB error
  input  wire logic                 EVT_VALID,   // Event strobe
  input  wire iohn_pkg::iohn_kind_e EVT_KIND,    // Event kind
  input  wire iohn_pkg::iohn_class_e EVT_CLASS,  // Request class
  input  wire logic                 EVT_WRITE,   // Request is a write
  input  wire logic                 EVT_EXCL,    // Exclusive request
  input  wire logic                 EVT_CFG_BAD, // Illegal config format
  input  wire logic                 EVT_REQERR,  // Request was flagged
  input  wire logic                 EVT_CFG,     // Config write data
  input  wire logic                 EVT_PART_BE, // Partial byte enable
  input  wire logic                 EVT_CHKERR,  // Data check error
  input  wire logic                 EVT_POISON,  // Poison on data
  input  wire logic [1:0]           EVT_RESP,    // BRESP or RRESP
  input  wire logic                 EVT_EARLY,   // Early completion sent
  input  wire logic [31:0]          INF_ADDR,    // Transaction address
  input  wire logic [10:0]          INF_SRCID,   // Source id
  input  wire logic [11:0]          INF_TXNID,   // Transaction id
  input  wire logic [5:0]           INF_OPCODE,  // Opcode
  input  wire logic [2:0]           INF_SIZE,    // Size
  input  wire logic [3:0]           INF_MEMATTR, // Memory attributes
  input  wire logic [1:0]           INF_ORDER,   // Order
  input  wire logic [4:0]           INF_LPID,    // Logical processor id
  output logic                      RSP_VALID,   // Decision strobe
  output logic      [1:0]           RSP_ERR,     // Response error code
  output logic                      RSP_POISON,  // Poison toward requester
  output logic                      RSP_FWD,     // Send downstream
  output logic                      RSP_DOWNGRADE, // Send as no-snoop
  output logic                      RSP_DROP     // Drop the write
);
  import iohn_pkg::*;

  logic [4:0]  cfg_reg;
  logic [3:0]  stat_reg;
  logic [31:0] addr_reg;
  logic [63:0] misc_reg;
  logic        boot_reg;
  logic        vld_reg;
  logic [1:0]  err_reg;
  logic        psn_reg;
  logic        fwd_reg;
  logic        dgr_reg;
  logic        drop_reg;
  logic [3:0]  stat_next;

  // Bus decode
  wire apb_acc   = PSEL && PENABLE;
  wire apb_wr    = apb_acc && PWRITE;
  wire hit_cfg   = PADDR == `IOHN_OFF_CFG;
  wire hit_stat  = PADDR == `IOHN_OFF_STATUS;
  wire hit_addr  = PADDR == `IOHN_OFF_ADDR;
  wire hit_mlo   = PADDR == `IOHN_OFF_MISC_LO;
  wire hit_mhi   = PADDR == `IOHN_OFF_MISC_HI;
  wire hit_clr   = PADDR == `IOHN_OFF_CLEAR;
  wire hit_any   = hit_cfg || hit_stat || hit_addr || hit_mlo || hit_mhi
                   || hit_clr;
  wire wr_cfg    = apb_wr && hit_cfg;
  wire wr_clr    = apb_wr && hit_clr;
  wire [31:0] rd_data = hit_cfg  ? {27'h0, cfg_reg} :
                        hit_stat ? {28'h0, stat_reg} :
                        hit_addr ? addr_reg :
                        hit_mlo  ? misc_reg[31:0] :
                        hit_mhi  ? misc_reg[63:32] : 32'h0;

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && !hit_any;
  assign PRDATA  = (apb_acc && !PWRITE) ? rd_data : 32'h0;

  wire coh_en   = cfg_reg[`IOHN_CFG_COH_EN];
  wire excl_dis = cfg_reg[`IOHN_CFG_EXCL_DIS];
  wire ds_psn   = cfg_reg[`IOHN_CFG_DS_PSN];
  wire is_dflt  = cfg_reg[`IOHN_CFG_DFLT];
  wire is_per   = cfg_reg[`IOHN_CFG_PERIPH];

  // Request classification
  wire ev_req  = EVT_VALID && EVT_KIND == IOHN_EV_REQ;
  wire ev_wd   = EVT_VALID && EVT_KIND == IOHN_EV_WDAT;
  wire ev_br   = EVT_VALID && EVT_KIND == IOHN_EV_BRESP;
  wire ev_rr   = EVT_VALID && EVT_KIND == IOHN_EV_RRESP;
  wire c_cohrd = EVT_CLASS == IOHN_RQ_COH_RD;
  wire c_clnmk = EVT_CLASS == IOHN_RQ_CLN_MK;
  wire c_cohwr = EVT_CLASS == IOHN_RQ_COH_WR;
  wire c_atom  = EVT_CLASS == IOHN_RQ_ATOMIC;
  wire c_stash = EVT_CLASS == IOHN_RQ_STASH;
  wire c_cfg   = EVT_CLASS == IOHN_RQ_CFG;
  wire c_nonc  = EVT_CLASS == IOHN_RQ_NONCOH;
  wire coh_cls = c_cohrd || c_clnmk || c_cohwr;
  wire cfg_bad = is_dflt && c_cfg && EVT_CFG_BAD;
  wire excl_nc = is_per && EVT_EXCL && c_nonc;
  wire excl_er = excl_nc && !excl_dis;
  wire excl_ok = excl_nc && excl_dis;
  wire req_err = ev_req && ((coh_cls && coh_en)
                 || c_atom || cfg_bad
                 || excl_er);
  wire req_fwd = c_cohrd || c_cohwr
                 || (c_cfg && !EVT_WRITE)
                 || c_nonc;
  wire req_loc = c_clnmk || c_atom || c_stash
                 || (cfg_bad && EVT_WRITE) || c_cfg && EVT_WRITE;

  // Write data checks
  wire wd_chk  = ev_wd && !EVT_REQERR;
  wire wd_cfg  = wd_chk && EVT_CFG
                 && (EVT_PART_BE || EVT_CHKERR || EVT_POISON);
  wire wd_unc  = wd_chk && !EVT_CFG && EVT_POISON && !ds_psn;

  // Downstream responses
  wire br_chk  = ev_br && !EVT_REQERR;
  wire br_bad  = EVT_RESP == `IOHN_AX_SLVERR
                 || EVT_RESP == `IOHN_AX_DECERR;
  wire br_unc  = br_chk && EVT_EARLY && br_bad;
  wire br_ndat = br_chk && !EVT_EARLY
                 && EVT_RESP == `IOHN_AX_DECERR;
  wire br_derr = br_chk && !EVT_EARLY
                 && EVT_RESP == `IOHN_AX_SLVERR;
  wire rr_psn  = ev_rr && (EVT_RESP == `IOHN_AX_SLVERR
                 || EVT_POISON);
  wire rr_ndat = ev_rr && EVT_RESP == `IOHN_AX_DECERR;

  // Error kinds reported in the response field
  wire ndat_out = req_err || wd_cfg || br_ndat || rr_ndat;
  wire [1:0] err_out = ndat_out ? `IOHN_RE_NDERR :
                       br_derr  ? `IOHN_RE_DERR :
                       (ev_req && excl_ok) ? `IOHN_RE_EXOK :
                       `IOHN_RE_OK;

  // Logging triggers
  wire log_dfr = req_err || wd_cfg;
  wire log_unc = wd_unc || br_unc;
  wire log_any = log_dfr || log_unc;
  wire first   = log_any && !stat_reg[`IOHN_ST_V];
  wire [3:0] esrc = ev_req ? `IOHN_SRC_REQ :
                    ev_wd  ? `IOHN_SRC_WDAT : `IOHN_SRC_BRESP;
  // Config data errors keep only the ids, per the drop path
  wire [63:0] misc_in = wd_cfg ?
    {32'h0, 4'h0, INF_TXNID, 1'b0, INF_SRCID, esrc} :
    {6'h0, 1'b0, INF_LPID, 2'h0, INF_ORDER, 16'h0,
     1'b0, INF_SIZE, INF_MEMATTR, 2'h0, INF_OPCODE,
     1'b0, INF_SRCID, esrc};

  // Clear of valid or multiple flags loses to a same-cycle log
  always_comb
  begin
    stat_next = stat_reg;
    if (wr_clr && PWDATA[`IOHN_ST_V])
    begin
      stat_next[`IOHN_ST_V]  = 1'b0;
      stat_next[`IOHN_ST_UNC] = 1'b0;
      stat_next[`IOHN_ST_DFR] = 1'b0;
    end
    if (wr_clr && PWDATA[`IOHN_ST_MV])
      stat_next[`IOHN_ST_MV] = 1'b0;
    if (log_any)
    begin
      if (stat_reg[`IOHN_ST_V])
        stat_next[`IOHN_ST_MV] = 1'b1;
      stat_next[`IOHN_ST_V] = 1'b1;
      if (log_dfr)
        stat_next[`IOHN_ST_DFR] = 1'b1;
      if (log_unc)
        stat_next[`IOHN_ST_UNC] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_reg  <= `IOHN_CFG_RESET;
      boot_reg <= 1'b1;
    end
    else
    begin
      // Coherent enable frozen once traffic starts
      if (wr_cfg)
        cfg_reg <= {PWDATA[4:1],
                    boot_reg ? PWDATA[0] : cfg_reg[0]};
      if (EVT_VALID)
        boot_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stat_reg <= 4'h0;
      addr_reg <= 32'h0;
      misc_reg <= 64'h0;
    end
    else
    begin
      stat_reg <= stat_next;
      if (first)
      begin
        addr_reg <= INF_ADDR;
        misc_reg <= misc_in;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      vld_reg  <= 1'b0;
      err_reg  <= `IOHN_RE_OK;
      psn_reg  <= 1'b0;
      fwd_reg  <= 1'b0;
      dgr_reg  <= 1'b0;
      drop_reg <= 1'b0;
    end
    else
    begin
      vld_reg  <= EVT_VALID;
      err_reg  <= EVT_VALID ? err_out : `IOHN_RE_OK;
      psn_reg  <= rr_psn;
      fwd_reg  <= ev_req && req_fwd && !req_loc;
      dgr_reg  <= ev_req && (c_cohrd || c_cohwr
                  || (cfg_bad && !EVT_WRITE));
      drop_reg <= wd_cfg;
    end
  end

  assign RSP_VALID     = vld_reg;
  assign RSP_ERR       = err_reg;
  assign RSP_POISON    = psn_reg;
  assign RSP_FWD       = fwd_reg;
  assign RSP_DOWNGRADE = dgr_reg;
  assign RSP_DROP      = drop_reg;

  // Checks
  property p_atomic_ndat;
    @(posedge CLK) disable iff (RST)
    ev_req && c_atom |=> RSP_ERR == `IOHN_RE_NDERR && !RSP_FWD;
  endproperty
  a_atomic_ndat: assert property (p_atomic_ndat)
    else $error("atomic without non-data error");

  property p_coh_off;
    @(posedge CLK) disable iff (RST)
    ev_req && coh_cls && !coh_en |=> RSP_ERR == `IOHN_RE_OK;
  endproperty
  a_coh_off: assert property (p_coh_off)
    else $error("coherent error while disabled");

  property p_coh_fwd;
    @(posedge CLK) disable iff (RST)
    ev_req && c_cohrd && coh_en |=> RSP_FWD && RSP_DOWNGRADE
      && RSP_ERR == `IOHN_RE_NDERR;
  endproperty
  a_coh_fwd: assert property (p_coh_fwd)
    else $error("coherent read not downgraded");

  property p_stash;
    @(posedge CLK) disable iff (RST)
    ev_req && c_stash |=> RSP_ERR == `IOHN_RE_OK && !RSP_FWD
      && $stable(stat_reg);
  endproperty
  a_stash: assert property (p_stash)
    else $error("stash flagged or forwarded");

  property p_excl_pass;
    @(posedge CLK) disable iff (RST)
    ev_req && excl_ok |=> RSP_ERR == `IOHN_RE_EXOK && $stable(stat_reg);
  endproperty
  a_excl_pass: assert property (p_excl_pass)
    else $error("exclusive pass missing");

  property p_log_dfr;
    @(posedge CLK) disable iff (RST)
    req_err && !stat_reg[`IOHN_ST_V] |=> stat_reg[`IOHN_ST_V]
      && stat_reg[`IOHN_ST_DFR] && addr_reg == $past(INF_ADDR);
  endproperty
  a_log_dfr: assert property (p_log_dfr)
    else $error("request error not logged");

  property p_wd_skip;
    @(posedge CLK) disable iff (RST)
    ev_wd && EVT_REQERR && !wr_clr |=> $stable(stat_reg) && !RSP_DROP;
  endproperty
  a_wd_skip: assert property (p_wd_skip)
    else $error("flagged request data checked");

  property p_cfg_drop;
    @(posedge CLK) disable iff (RST)
    wd_cfg |=> RSP_DROP && RSP_ERR == `IOHN_RE_NDERR
      && stat_reg[`IOHN_ST_DFR];
  endproperty
  a_cfg_drop: assert property (p_cfg_drop)
    else $error("bad config write not dropped");

  property p_br_early;
    @(posedge CLK) disable iff (RST)
    br_unc |=> stat_reg[`IOHN_ST_UNC] && RSP_ERR == `IOHN_RE_OK;
  endproperty
  a_br_early: assert property (p_br_early)
    else $error("early write error not uncorrected");

  property p_br_slv;
    @(posedge CLK) disable iff (RST)
    br_derr |=> RSP_ERR == `IOHN_RE_DERR;
  endproperty
  a_br_slv: assert property (p_br_slv)
    else $error("slave error not data error");

  property p_rr;
    @(posedge CLK) disable iff (RST)
    ev_rr |=> RSP_POISON == ($past(EVT_RESP) == `IOHN_AX_SLVERR
      || $past(EVT_POISON))
      && (RSP_ERR == `IOHN_RE_NDERR)
      == ($past(EVT_RESP) == `IOHN_AX_DECERR);
  endproperty
  a_rr: assert property (p_rr)
    else $error("read response mistranslated");

  property p_clear;
    @(posedge CLK) disable iff (RST)
    wr_clr && PWDATA[`IOHN_ST_V] && !log_any |=> !stat_reg[`IOHN_ST_V];
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not drop valid");

  c_multi: cover property (@(posedge CLK) disable iff (RST)
    stat_reg[`IOHN_ST_MV]);
  c_unc: cover property (@(posedge CLK) disable iff (RST) br_unc);
  c_drop: cover property (@(posedge CLK) disable iff (RST) wd_cfg);
  c_clr_log: cover property (@(posedge CLK) disable iff (RST)
    wr_clr && log_any);
endmodule

// ===== sim/iohn_err_far.sv
// Requester and downstream slave model presenting one event per call
`timescale 1ns/1ps
module iohn_err_far (
  input  wire logic        clk,      // Interconnect clock
  output logic             ev_valid, // Event strobe
  output logic [15:0]      ev_flags  // Packed event fields
);
  initial
  begin
    ev_valid = 1'b0;
    ev_flags = 16'h0000;
  end
  // Fields held over the taking edge only
  task automatic send(input logic [15:0] f);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev_flags <= f;
    @(posedge clk);
    ev_valid <= 1'b0;
    // Inverted so stale fields cannot pass for fresh ones
    ev_flags <= ~f;
  endtask
endmodule

// ===== sim/iohn_err_tb_top.sv
// Self-checking bench for the io home node error handler
`timescale 1ns/1ps
`include "iohn_err_map.svh"
`define CHK(n, e, a) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("MISMATCH %s exp %h got %h", n, e, a); \
    end \
  end
module iohn_err_tb_top;
  import iohn_pkg::*;
  localparam logic [1:0] re_ok = `IOHN_RE_OK;
  localparam logic [1:0] re_ex = `IOHN_RE_EXOK;
  localparam logic [1:0] re_dt = `IOHN_RE_DERR;
  localparam logic [1:0] re_nd = `IOHN_RE_NDERR;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, inf;
  logic        ev_valid, rsp_valid, rsp_poison, rsp_fwd, rsp_down, rsp_drop;
  logic [15:0] ev_flags;
  logic [1:0]  rsp_err;
  int          failures, checks, cyc;
  iohn_err i_iohn_err (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EVT_VALID(ev_valid),
    .EVT_KIND(iohn_kind_e'(ev_flags[1:0])),
    .EVT_CLASS(iohn_class_e'(ev_flags[4:2])), .EVT_WRITE(ev_flags[5]),
    .EVT_EXCL(ev_flags[6]), .EVT_CFG_BAD(ev_flags[7]),
    .EVT_REQERR(ev_flags[8]), .EVT_CFG(ev_flags[9]),
    .EVT_PART_BE(ev_flags[10]), .EVT_CHKERR(ev_flags[11]),
    .EVT_POISON(ev_flags[12]), .EVT_RESP(ev_flags[14:13]),
    .EVT_EARLY(ev_flags[15]), .INF_ADDR(inf), .INF_SRCID(inf[10:0]),
    .INF_TXNID(inf[31:20]), .INF_OPCODE(inf[16:11]), .INF_SIZE(inf[19:17]),
    .INF_MEMATTR(inf[23:20]), .INF_ORDER(inf[25:24]), .INF_LPID(inf[30:26]),
    .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .RSP_POISON(rsp_poison),
    .RSP_FWD(rsp_fwd), .RSP_DOWNGRADE(rsp_down), .RSP_DROP(rsp_drop)
  );
  iohn_err_far i_iohn_err_far (
    .clk(clk), .ev_valid(ev_valid), .ev_flags(ev_flags)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ends on the first edge that sees pready high
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic se);
    logic [31:0] q;
    logic        s;
    apb(1'b0, a, 32'h0, q, s);
    `CHK("prdata", e, q)
    `CHK("pslverr", se, s)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic se);
    logic [31:0] q;
    logic        s;
    apb(1'b1, a, d, q, s);
    `CHK("pslverr", se, s)
  endtask
  // Read status, then drop every flag for the next step
  task automatic stat(input logic [31:0] e);
    rd(`IOHN_OFF_STATUS, e, 1'b0);
    wr(`IOHN_OFF_CLEAR, 32'h3, 1'b0);
  endtask
  // b: early, resp[1:0], poison, chk, part_be, cfg, reqerr, cfg_bad, excl, wr
  // o: poison, fwd, downgrade, drop
  task automatic ev(input logic [1:0] k, input logic [2:0] c,
                    input logic [10:0] b, input logic [1:0] e,
                    input logic [3:0] o);
    @(posedge clk);
    inf <= {inf[30:0], inf[31] ^ inf[27]} ^ 32'h3c5a_a5c3;
    i_iohn_err_far.send({b, c, k});
    #1;
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_err", e, rsp_err)
    `CHK("rsp_flags", o, {rsp_poison, rsp_fwd, rsp_down, rsp_drop})
    @(posedge clk);
    #1;
    `CHK("rsp_pulse", 1'b0, rsp_valid)
  endtask
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    inf = 32'h1357_9bdf;
    failures = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`IOHN_OFF_CFG, {27'h0, `IOHN_CFG_RESET}, 1'b0);
    rd(`IOHN_OFF_STATUS, 32'h0, 1'b0);
    rd(`IOHN_OFF_CLEAR, 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    wr(12'h044, 32'hffff_ffff, 1'b1);
    wr(`IOHN_OFF_CFG, 32'h19, 1'b0);
    rd(`IOHN_OFF_CFG, 32'h19, 1'b0);
    ev(2'h0, 3'h1, 11'b0, re_nd, 4'b0110);
    rd(`IOHN_OFF_ADDR, inf, 1'b0);
    rd(`IOHN_OFF_MISC_LO, {1'b0, inf[19:17], inf[23:20], 2'b0, inf[16:11],
       1'b0, inf[10:0], `IOHN_SRC_REQ}, 1'b0);
    rd(`IOHN_OFF_MISC_HI, {7'h0, inf[30:26], 2'b0, inf[25:24], 16'h0},
       1'b0);
    ev(2'h0, 3'h2, 11'b0, re_nd, 4'b0000);
    ev(2'h0, 3'h4, 11'b0, re_nd, 4'b0000);
    ev(2'h0, 3'h3, 11'b1, re_nd, 4'b0110);
    ev(2'h0, 3'h5, 11'b0, re_ok, 4'b0000);
    ev(2'h0, 3'h6, 11'b100, re_nd, 4'b0110);
    ev(2'h0, 3'h6, 11'b101, re_nd, 4'b0000);
    ev(2'h0, 3'h0, 11'b10, re_nd, 4'b0100);
    stat(32'hb);
    rd(`IOHN_OFF_STATUS, 32'h0, 1'b0);
    wr(`IOHN_OFF_CFG, 32'h1a, 1'b0);
    rd(`IOHN_OFF_CFG, 32'h1b, 1'b0);
    ev(2'h0, 3'h0, 11'b10, re_ex, 4'b0100);
    ev(2'h1, 3'h0, 11'b00010011000, re_ok, 4'b0000);
    rd(`IOHN_OFF_STATUS, 32'h0, 1'b0);
    ev(2'h1, 3'h0, 11'b00000110000, re_nd, 4'b0001);
    ev(2'h1, 3'h0, 11'b00001010000, re_nd, 4'b0001);
    ev(2'h1, 3'h0, 11'b00010010000, re_nd, 4'b0001);
    stat(32'hb);
    ev(2'h1, 3'h0, 11'b00010000000, re_ok, 4'b0000);
    stat(32'h5);
    wr(`IOHN_OFF_CFG, 32'h1e, 1'b0);
    ev(2'h1, 3'h0, 11'b00010000000, re_ok, 4'b0000);
    stat(32'h0);
    ev(2'h2, 3'h0, 11'b11000000000, re_ok, 4'b0000);
    ev(2'h2, 3'h0, 11'b11100000000, re_ok, 4'b0000);
    stat(32'h7);
    ev(2'h2, 3'h0, 11'b01100000000, re_nd, 4'b0000);
    ev(2'h2, 3'h0, 11'b01000000000, re_dt, 4'b0000);
    ev(2'h2, 3'h0, 11'b01100001000, re_ok, 4'b0000);
    ev(2'h2, 3'h0, 11'b11000001000, re_ok, 4'b0000);
    stat(32'h0);
    ev(2'h3, 3'h0, 11'b01000000000, re_ok, 4'b1000);
    ev(2'h3, 3'h0, 11'b00010001000, re_ok, 4'b1000);
    ev(2'h3, 3'h0, 11'b01100001000, re_nd, 4'b0000);
    stat(32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`IOHN_OFF_CFG, {27'h0, `IOHN_CFG_RESET}, 1'b0);
    wr(`IOHN_OFF_CFG, 32'h18, 1'b0);
    ev(2'h0, 3'h1, 11'b0, re_ok, 4'b0110);
    ev(2'h0, 3'h4, 11'b0, re_nd, 4'b0000);
    stat(32'h9);
    finish_test();
  end
endmodule
